// File: verif/ivu_core_model.sv
`timescale 1ns/10ps
module ivu_core_model (
    input  wire logic                     i_clk,
    input  wire logic                     i_push,
    input  wire logic [ivu_pkg::PC_W-1:0] i_push_data,
    input  wire logic                     i_ret_req,
    output logic                          o_ret,
    output logic [ivu_pkg::PC_W-1:0]      o_top
);
    import ivu_pkg::*;
    logic [PC_W-1:0] stk[$];
    initial begin
        o_ret = 1'b0;
        o_top = 13'h1555;
    end
    // Stack top is only meaningful in the return clock; it churns otherwise
    always @(posedge i_clk) begin
        if (i_push === 1'b1) stk.push_back(i_push_data);
        o_ret <= 1'b0;
        o_top <= ~o_top;
        if (i_ret_req && !o_ret && stk.size() > 0) begin
            o_ret <= 1'b1;
            o_top <= stk.pop_back();
        end
    end
endmodule // ivu_core_model

// File: verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import ivu_pkg::*;
    logic            I_CLK, I_RSTN, psel, pen, pwr, tmr, pchg, pin, pc_wr, slp, ret_req;
    logic            er_v, push, flush, sleeping, ret, pready, pslverr;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata, rd_v, rs;
    logic [7:0]      pea, peb, pc_lo;
    logic [1:0]      qph;
    logic [PC_W-1:0] pc, pdata, top;
    logic [4:0]      notes[$];
    int              err_total, comparisons, fl_n, n;

    ivu_top ivu_top_inst (
        .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_TMR_EVT(tmr), .I_PORTCHG_EVT(pchg), .I_PERIPH_EVT_A(pea),
        .I_PERIPH_EVT_B(peb), .I_EXT_PIN(pin), .I_PCL_WR(pc_wr), .I_PCL_DATA(pc_lo),
        .I_RETURN_OP(ret), .I_STACK_TOP(top), .I_SLEEP_OP(slp), .O_PC(pc), .O_QPHASE(qph),
        .O_FLUSH(flush), .O_PUSH(push), .O_PUSH_DATA(pdata), .O_SLEEPING(sleeping)
    );
    ivu_core_model ivu_core_model_inst (
        .i_clk(I_CLK), .i_push(push), .i_push_data(pdata), .i_ret_req(ret_req),
        .o_ret(ret), .o_top(top)
    );

    initial begin
        I_CLK = 1'b0;
        forever #25 I_CLK = ~I_CLK;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task automatic complete_run;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [8:0] idx, input logic [31:0] wd);
        @(posedge I_CLK);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= {1'b0, idx, 2'b00};
        pwdata <= wd;
        @(posedge I_CLK);
        pen <= 1'b1;
        @(posedge I_CLK);
        while (pready !== 1'b1) @(posedge I_CLK);
        rd_v = prdata;
        er_v = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic rdc(input logic [8:0] idx, input logic [31:0] x);
        apb(1'b0, idx, 0);
        chk(rd_v, x);
    endtask

    task automatic at_q0;
        @(negedge I_CLK);
        while (qph !== Q_LAST) @(negedge I_CLK);
        @(posedge I_CLK);
    endtask

    // Counts clocks until the vector shows; 40 means none came
    task automatic wvec(output int k);
        k = 0;
        @(negedge I_CLK);
        while (pc !== IRQ_VECTOR && k < 40) begin
            k++;
            @(negedge I_CLK);
        end
    endtask

    // Event launched in the first phase of an instruction cycle
    task automatic fire(input logic kind, output int k);
        at_q0();
        if (kind) pin <= !pin;
        else tmr <= 1'b1;
        fork
            begin
                @(posedge I_CLK);
                tmr <= 1'b0;
            end
            wvec(k);
        join
    endtask

    task automatic do_ret;
        @(posedge I_CLK);
        ret_req <= 1'b1;
        @(negedge I_CLK);
        while (ret !== 1'b1) @(negedge I_CLK);
        rd_v = top;
        @(posedge I_CLK);
        ret_req <= 1'b0;
        @(negedge I_CLK);
        chk(pc, rd_v);
    endtask

    task automatic nap(output int k);
        @(posedge I_CLK);
        slp <= 1'b1;
        @(posedge I_CLK);
        slp <= 1'b0;
        @(negedge I_CLK);
        chk(sleeping, 1'b1);
        @(posedge I_CLK);
        tmr <= 1'b1;
        @(posedge I_CLK);
        tmr <= 1'b0;
        while (sleeping === 1'b1) @(negedge I_CLK);
        wvec(k);
    endtask

    // Every stacking must have been announced by the driver
    always @(negedge I_CLK) begin
        if (flush === 1'b1) fl_n++;
        if (push === 1'b1) begin
            chk(fl_n, 4);
            fl_n = 0;
            if (notes.size() == 0) chk(1'b1, 1'b0);
            else chk(pdata[12:8], notes.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge I_CLK);
        err_total++;
        complete_run();
    end

    initial begin
        {I_RSTN, psel, pen, pwr, tmr, pchg, pin, pc_wr, slp, ret_req} = '0;
        {paddr, pwdata, pea, peb, pc_lo} = '0;
        {err_total, comparisons, fl_n} = '0;
        rs = xs(32'h167e);
        repeat (20) @(posedge I_CLK);
        I_RSTN <= 1'b1;
        repeat (3) @(posedge I_CLK);
        rdc(IDX_IRQCTL, RST_IRQCTL);
        rdc(IDX_OPTION, RST_OPTION);
        rdc(IDX_PEN_B, RST_PREG);
        apb(1'b0, 9'h055, 0);
        chk(er_v, 1'b1);
        chk(rd_v, 32'h0);
        apb(1'b1, IDX_PCHL_M, {rs[31:8], 8'h05});
        rdc(9'h00a, 32'h05);
        @(posedge I_CLK);
        {pc_wr, pc_lo} <= {1'b1, rs[23:16]};
        @(posedge I_CLK);
        pc_wr <= 1'b0;
        @(negedge I_CLK);
        chk(pc, {5'h05, rs[23:16]});
        at_q0();
        {tmr, pchg, pea, peb} <= {2'b11, rs[15:8] | 8'h01, rs[7:0]};
        @(posedge I_CLK);
        {tmr, pchg, pea, peb} <= '0;
        rdc(IDX_PFLAG_A, rs[15:8] | 8'h01);
        rdc(IDX_PFLAG_B, rs[7:0]);
        apb(1'b1, IDX_PEN_A, 32'h01);
        apb(1'b1, IDX_IRQCTL, 32'h85);
        repeat (16) @(posedge I_CLK);
        rdc(IDX_IRQCTL_M, 32'h85);
        notes.push_back(5'h05);
        apb(1'b1, IDX_IRQCTL, 32'hc5);
        wvec(n);
        chk(n < 40, 1'b1);
        apb(1'b1, IDX_PFLAG_A, 0);
        apb(1'b1, IDX_IRQCTL, 0);
        do_ret();
        rdc(IDX_IRQCTL, 32'h80);
        apb(1'b1, IDX_IRQCTL, 32'ha0);
        notes.push_back(5'h05);
        fire(1'b0, n);
        chk(n, 12);
        rdc(IDX_IRQCTL, 32'h24);
        rdc(IDX_PCHL, 32'h05);
        apb(1'b1, IDX_PCHL, rd_v);
        notes.push_back(5'h05);
        do_ret();
        wvec(n);
        chk(n < 40, 1'b1);
        apb(1'b1, IDX_IRQCTL, 32'h20);
        do_ret();
        rdc(IDX_IRQCTL, 32'ha0);
        apb(1'b1, IDX_IRQCTL, 32'h20);
        fire(1'b0, n);
        chk(n, 40);
        notes.push_back(5'h05);
        apb(1'b1, IDX_IRQCTL, 32'ha4);
        wvec(n);
        chk(n < 40, 1'b1);
        apb(1'b1, IDX_IRQCTL, 32'h20);
        do_ret();
        for (int e = 1; e >= 0; e--) begin
            apb(1'b1, IDX_OPTION, e ? 32'hff : 32'hbf);
            @(posedge I_CLK);
            pin <= !e;
            apb(1'b1, IDX_IRQCTL, 32'h90);
            notes.push_back(5'h05);
            fire(1'b1, n);
            chk((n >= 12) && (n <= 16), 1'b1);
            rdc(IDX_IRQCTL, 32'h12);
            apb(1'b1, IDX_IRQCTL, 32'h10);
            do_ret();
            fire(1'b1, n);
            chk(n, 40);
            rdc(IDX_IRQCTL, 32'h90);
        end
        apb(1'b1, IDX_IRQCTL, 32'h20);
        nap(n);
        chk(n, 40);
        apb(1'b1, IDX_IRQCTL, 32'ha0);
        notes.push_back(5'h05);
        nap(n);
        chk((n > 9) && (n < 40), 1'b1);
        chk(notes.size(), 0);
        complete_run();
    end
endmodule // tb_top

// File: verilog/ivu_pkg.sv
package ivu_pkg;

    localparam int              PC_W         = 13;
    localparam logic [12:0]     IRQ_VECTOR   = 13'h0004;
    localparam logic [12:0]     RST_PC       = 13'h0000;

    // Register indexes; byte address is four times the index
    localparam logic [8:0]      IDX_PCHL     = 9'h10a;
    localparam logic [8:0]      IDX_IRQCTL   = 9'h10b;
    localparam logic [8:0]      IDX_OPTION   = 9'h181;
    localparam logic [8:0]      IDX_PCHL_M   = 9'h18a;
    localparam logic [8:0]      IDX_IRQCTL_M = 9'h18b;
    localparam logic [8:0]      IDX_PFLAG_A  = 9'h00c;
    localparam logic [8:0]      IDX_PFLAG_B  = 9'h00d;
    localparam logic [8:0]      IDX_PEN_A    = 9'h08c;
    localparam logic [8:0]      IDX_PEN_B    = 9'h08d;

    // Bit positions in irq_control_flags
    localparam int              B_GIE        = 7;
    localparam int              B_PERIPH_IRQ_ENABLE       = 6;
    localparam int              B_TIE        = 5;
    localparam int              B_PIE        = 4;
    localparam int              B_RBIE       = 3;
    localparam int              B_TIF        = 2;
    localparam int              B_PIF        = 1;
    localparam int              B_RBIF       = 0;
    // Bit position of pin_irq_edge_sel in options_and_edge_select
    localparam int              B_EDGE       = 6;

    localparam logic [7:0]      RST_IRQCTL   = 8'h00;
    localparam logic [7:0]      RST_OPTION   = 8'hff;
    localparam logic [4:0]      RST_PCHL     = 5'h00;
    localparam logic [7:0]      RST_PREG     = 8'h00;
    localparam logic [1:0]      Q_LAST       = 2'h3;

    typedef enum logic [4:0] {
        ST_RUN   = 5'b00001,
        ST_FLUSH = 5'b00010,
        ST_PUSH  = 5'b00100,
        ST_SLEEP = 5'b01000,
        ST_WAKE  = 5'b10000
    } ivu_st_t;

    typedef struct packed {
        ivu_st_t        st;
        logic [1:0]     q;
        logic [7:0]     ictl;
        logic [7:0]     opt;
        logic [4:0]     pchl;
        logic [7:0]     pfa;
        logic [7:0]     pfb;
        logic [7:0]     pea;
        logic [7:0]     peb;
        logic [12:0]    pc;
        logic           pin;
        logic           pin_ok;
        logic [31:0]    rdata;
    } ivu_state_t;

    // Registers mirrored in every bank match on the in-bank offset only
    function automatic logic bank_hit(input logic [8:0] idx, input logic [8:0] base);
        return idx[6:0] == base[6:0];
    endfunction

endpackage

// File: verilog/ivu_top.sv
`timescale 1ns/10ps
// Function
// - Any reset leaves global enable and all interrupt enables cleared.
// - Vectoring needs global enable and source enable; peripherals also need group enable.
// - Flags set on their events regardless of any enable bit.
// - Vectoring flushes prefetch, clears global enable, pushes PC, loads 0004h.
// - One shared vector; handler finds the source by reading flags.
// - A flag left set with its enable requests again when global enable returns.
// - With global enable clear events set flags, and enabled ones wake sleep without vectoring; serviced once it is set.
// - Return op pops saved address into PC and sets global enable together.
// - Synchronous sources reach the vector exactly three instruction cycles later.
// - Asynchronous sources reach the vector three or four cycles later.
// - The pin flag can be set during any phase from Q4 through Q1.
// - An enabled clockless source wakes the core from sleep.
// - The instruction after sleep always executes before the vector branch.
// - Pin interrupt is edge triggered; edge select picks rising or falling edge.
// - Valid pin edge sets pin flag; vectoring also needs pin and global enables.
// - Only the return PC is saved; no other register is stacked.
// - Loading the vector leaves the PC high latch unchanged.
// - Upper PC bits hidden; latch bits move into PC when the low byte is written.
// - Control register and PC latch appear at the same offset in every bank.
module ivu_top (
    input  wire logic                   I_CLK,
    input  wire logic                   I_RSTN,
    input  wire logic                   I_PSEL,
    input  wire logic                   I_PENABLE,
    input  wire logic                   I_PWRITE,
    input  wire logic [11:0]            I_PADDR,
    input  wire logic [31:0]            I_PWDATA,
    output wire logic [31:0]            O_PRDATA,
    output wire logic                   O_PREADY,
    output wire logic                   O_PSLVERR,
    input  wire logic                   I_TMR_EVT,
    input  wire logic                   I_PORTCHG_EVT,
    input  wire logic [7:0]             I_PERIPH_EVT_A,
    input  wire logic [7:0]             I_PERIPH_EVT_B,
    input  wire logic                   I_EXT_PIN,
    input  wire logic                   I_PCL_WR,
    input  wire logic [7:0]             I_PCL_DATA,
    input  wire logic                   I_RETURN_OP,
    input  wire logic [ivu_pkg::PC_W-1:0] I_STACK_TOP,
    input  wire logic                   I_SLEEP_OP,
    output wire logic [ivu_pkg::PC_W-1:0] O_PC,
    output wire logic [1:0]             O_QPHASE,
    output wire logic                   O_FLUSH,
    output wire logic                   O_PUSH,
    output wire logic [ivu_pkg::PC_W-1:0] O_PUSH_DATA,
    output wire logic                   O_SLEEPING
);
    import ivu_pkg::*;

    logic [1:0]     rsync_q;
    logic           rst_n;
    ivu_state_t     s_q;
    ivu_state_t     s_d;
    logic [8:0]     idx;
    logic           wr;
    logic           rd_setup;
    logic           hit_pchl;
    logic           hit_ictl;
    logic           hit_opt;
    logic           hit_pfa;
    logic           hit_pfb;
    logic           hit_pea;
    logic           hit_peb;
    logic           hit_any;
    logic           cyc_end;
    logic           pin_edge;
    logic           periph_req;
    logic           src_req;
    logic           pend;
    logic           wake;
    logic [7:0]     rd_mux;

    // Reset release through two flops
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rsync_q <= 2'b00;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end
    assign rst_n = rsync_q[1];

    assign idx      = I_PADDR[10:2];
    assign wr       = I_PSEL & I_PENABLE & I_PWRITE;
    assign rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;
    assign hit_pchl = bank_hit(idx, IDX_PCHL);
    assign hit_ictl = bank_hit(idx, IDX_IRQCTL);
    assign hit_opt  = idx == IDX_OPTION;
    assign hit_pfa  = idx == IDX_PFLAG_A;
    assign hit_pfb  = idx == IDX_PFLAG_B;
    assign hit_pea  = idx == IDX_PEN_A;
    assign hit_peb  = idx == IDX_PEN_B;
    assign hit_any  = hit_pchl | hit_ictl | hit_opt | hit_pfa | hit_pfb | hit_pea | hit_peb;

    assign cyc_end  = s_q.q == Q_LAST;

    // Pin edge seen in any Q phase, so the flag may set from Q4 through Q1
    assign pin_edge = s_q.pin_ok & (s_q.opt[B_EDGE] ? (I_EXT_PIN & ~s_q.pin)
                                                    : (~I_EXT_PIN & s_q.pin));

    assign periph_req = s_q.ictl[B_PERIPH_IRQ_ENABLE] & (|(s_q.pfa & s_q.pea) | |(s_q.pfb & s_q.peb));
    assign src_req = (s_q.ictl[B_TIE] & s_q.ictl[B_TIF])
                   | (s_q.ictl[B_PIE] & s_q.ictl[B_PIF])
                   | (s_q.ictl[B_RBIE] & s_q.ictl[B_RBIF])
                   | periph_req;
    // Flags are levels, so an unserviced one requests again when enabled
    assign pend = s_q.ictl[B_GIE] & src_req;
    assign wake = src_req;

    always_comb begin
        unique case (1'b1)
            hit_pchl: rd_mux = {3'h0, s_q.pchl};
            hit_ictl: rd_mux = s_q.ictl;
            hit_opt:  rd_mux = s_q.opt;
            hit_pfa:  rd_mux = s_q.pfa;
            hit_pfb:  rd_mux = s_q.pfb;
            hit_pea:  rd_mux = s_q.pea;
            hit_peb:  rd_mux = s_q.peb;
            default:  rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.q = 2'(s_q.q + 2'h1);
        s_d.pin = I_EXT_PIN;
        s_d.pin_ok = 1'b1;
        if (rd_setup) begin
            s_d.rdata = {24'h0, rd_mux};
        end
        if (wr && hit_pchl) begin
            s_d.pchl = I_PWDATA[4:0];
        end
        if (wr && hit_ictl) begin
            s_d.ictl = I_PWDATA[7:0];
        end
        if (wr && hit_opt) begin
            s_d.opt = I_PWDATA[7:0];
        end
        if (wr && hit_pfa) begin
            s_d.pfa = I_PWDATA[7:0];
        end
        if (wr && hit_pfb) begin
            s_d.pfb = I_PWDATA[7:0];
        end
        if (wr && hit_pea) begin
            s_d.pea = I_PWDATA[7:0];
        end
        if (wr && hit_peb) begin
            s_d.peb = I_PWDATA[7:0];
        end
        // Hardware sets win over a software clear in the same cycle
        s_d.ictl[B_TIF]  = s_d.ictl[B_TIF] | I_TMR_EVT;
        s_d.ictl[B_RBIF] = s_d.ictl[B_RBIF] | I_PORTCHG_EVT;
        s_d.ictl[B_PIF]  = s_d.ictl[B_PIF] | pin_edge;
        s_d.pfa = s_d.pfa | I_PERIPH_EVT_A;
        s_d.pfb = s_d.pfb | I_PERIPH_EVT_B;
        unique case (s_q.st)
            ST_RUN: begin
                if (I_RETURN_OP) begin
                    s_d.pc = I_STACK_TOP;
                    s_d.ictl[B_GIE] = 1'b1;
                end else if (I_PCL_WR) begin
                    s_d.pc = {s_q.pchl, I_PCL_DATA};
                end else if (I_SLEEP_OP) begin
                    s_d.st = ST_SLEEP;
                end else if (cyc_end) begin
                    // Decision at cycle end: an edge after it waits a cycle
                    if (pend) begin
                        s_d.st = ST_FLUSH;
                    end else begin
                        s_d.pc = 13'(s_q.pc + 13'h1);
                    end
                end
            end
            ST_FLUSH: begin
                // Prefetched instruction dropped; PC holds the return address
                if (cyc_end) begin
                    s_d.st = ST_PUSH;
                end
            end
            ST_PUSH: begin
                if (cyc_end) begin
                    s_d.ictl[B_GIE] = 1'b0;
                    // Single shared vector; latch left alone
                    s_d.pc = IRQ_VECTOR;
                    s_d.st = ST_RUN;
                end
            end
            ST_SLEEP: begin
                if (cyc_end && wake) begin
                    s_d.st = ST_WAKE;
                end
            end
            ST_WAKE: begin
                // Instruction after sleep runs before any vector branch
                if (I_PCL_WR) begin
                    s_d.pc = {s_q.pchl, I_PCL_DATA};
                end else if (cyc_end) begin
                    s_d.pc = 13'(s_q.pc + 13'h1);
                end
                if (cyc_end) begin
                    s_d.st = ST_RUN;
                end
            end
            default: begin
                s_d.st = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_q.st     <= ST_RUN;
            s_q.q      <= 2'h0;
            s_q.ictl   <= RST_IRQCTL;
            s_q.opt    <= RST_OPTION;
            s_q.pchl   <= RST_PCHL;
            s_q.pfa    <= RST_PREG;
            s_q.pfb    <= RST_PREG;
            s_q.pea    <= RST_PREG;
            s_q.peb    <= RST_PREG;
            s_q.pc     <= RST_PC;
            s_q.pin    <= 1'b0;
            s_q.pin_ok <= 1'b0;
            s_q.rdata  <= 32'h0;
        end else begin
            s_q <= s_d;
        end
    end

    assign O_PRDATA    = s_q.rdata;
    assign O_PREADY    = 1'b1;
    assign O_PSLVERR   = I_PSEL & I_PENABLE & ~hit_any;
    assign O_PC        = s_q.pc;
    assign O_QPHASE    = s_q.q;
    assign O_FLUSH     = s_q.st == ST_FLUSH;
    assign O_PUSH      = (s_q.st == ST_PUSH) & cyc_end;
    assign O_PUSH_DATA = s_q.pc;
    assign O_SLEEPING  = s_q.st == ST_SLEEP;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!rst_n);

    reset_gie_off_a: assert property (
        $rose(rst_n) |-> (s_q.ictl == RST_IRQCTL && s_q.pea == RST_PREG))
        else $error("enables not clear after reset");

    vec_needs_gie_a: assert property (
        $rose(s_q.st == ST_FLUSH) |-> $past(s_q.ictl[B_GIE]) && $past(src_req))
        else $error("vectored without global enable or request");

    flag_sets_a: assert property (
        I_PORTCHG_EVT |=> s_q.ictl[B_RBIF])
        else $error("port change event did not set its flag");

    tmr_flag_a: assert property (
        I_TMR_EVT |=> s_q.ictl[B_TIF])
        else $error("timer event did not set its flag");

    vec_sequence_a: assert property (
        (s_q.st == ST_RUN && cyc_end && pend && !I_RETURN_OP && !I_PCL_WR && !I_SLEEP_OP)
        |=> (s_q.st == ST_FLUSH)[*4] ##1 (s_q.st == ST_PUSH)[*4]
            ##1 (s_q.st == ST_RUN && s_q.pc == IRQ_VECTOR && !s_q.ictl[B_GIE]))
        else $error("vector sequence or latency wrong");

    latch_kept_a: assert property (
        (O_PUSH && !(wr && hit_pchl)) |=> s_q.pchl == $past(s_q.pchl))
        else $error("vector load changed PC latch");

    push_pc_a: assert property (
        O_PUSH |-> O_PUSH_DATA == $past(s_q.pc, 4))
        else $error("pushed PC is not the return address");

    return_gie_a: assert property (
        (I_RETURN_OP && s_q.st == ST_RUN)
        |=> s_q.ictl[B_GIE] && s_q.pc == $past(I_STACK_TOP))
        else $error("return did not restore PC and global enable");

    pin_edge_a: assert property (
        (s_q.pin_ok && !s_q.opt[B_EDGE] && !I_EXT_PIN && s_q.pin) |=> s_q.ictl[B_PIF])
        else $error("falling edge missed pin flag");

    wake_step_a: assert property (
        (s_q.st == ST_SLEEP && cyc_end && wake)
        |=> (s_q.st == ST_WAKE && !O_FLUSH)[*4] ##1 s_q.st == ST_RUN)
        else $error("wake did not run one instruction first");

    pcl_load_a: assert property (
        (I_PCL_WR && s_q.st == ST_RUN && !I_RETURN_OP)
        |=> s_q.pc == {$past(s_q.pchl), $past(I_PCL_DATA)})
        else $error("PC low write did not merge latch");

    mirror_read_a: assert property (
        (rd_setup && idx == IDX_IRQCTL_M) |=> O_PRDATA[7:0] == $past(s_q.ictl))
        else $error("mirrored control register read wrong");

    periph_flag_a: assert property (
        ((|I_PERIPH_EVT_A) || (|I_PERIPH_EVT_B))
        |=> (s_q.pfa & $past(I_PERIPH_EVT_A)) == $past(I_PERIPH_EVT_A)
            && (s_q.pfb & $past(I_PERIPH_EVT_B)) == $past(I_PERIPH_EVT_B))
        else $error("peripheral event did not set its flag");

    rise_edge_a: assert property (
        (s_q.pin_ok && s_q.opt[B_EDGE] && I_EXT_PIN && !s_q.pin) |=> s_q.ictl[B_PIF])
        else $error("rising edge missed pin flag");

    no_edge_a: assert property (
        ((I_EXT_PIN != s_q.opt[B_EDGE] || s_q.pin == s_q.opt[B_EDGE]) && !(wr && hit_ictl))
        |=> $stable(s_q.ictl[B_PIF]))
        else $error("pin flag set without a valid edge");

    no_vec_off_a: assert property (
        (s_q.st == ST_RUN && cyc_end && !s_q.ictl[B_GIE]) |=> s_q.st != ST_FLUSH)
        else $error("vectored while global enable clear");

    group_gate_a: assert property (
        (s_q.st == ST_RUN && cyc_end && !s_q.ictl[B_PERIPH_IRQ_ENABLE]
         && !(s_q.ictl[B_TIE] && s_q.ictl[B_TIF]) && !(s_q.ictl[B_PIE] && s_q.ictl[B_PIF])
         && !(s_q.ictl[B_RBIE] && s_q.ictl[B_RBIF])) |=> s_q.st != ST_FLUSH)
        else $error("peripheral flag vectored without group enable");

    flush_len_a: assert property (
        $rose(O_FLUSH) |-> O_FLUSH[*4] ##1 (!O_FLUSH && !O_PUSH))
        else $error("flush did not last one instruction cycle");

    vec_entry_a: assert property (
        O_PUSH |=> (s_q.pc == IRQ_VECTOR && !s_q.ictl[B_GIE] && s_q.q == 2'h0))
        else $error("push not followed by vector entry");

    sleep_enter_a: assert property (
        (s_q.st == ST_RUN && I_SLEEP_OP && !I_RETURN_OP && !I_PCL_WR) |=> O_SLEEPING)
        else $error("sleep op did not enter sleep");

    sleep_hold_a: assert property (
        (O_SLEEPING && !(cyc_end && wake)) |=> O_SLEEPING && s_q.pc == $past(s_q.pc))
        else $error("left sleep without an enabled request");

    latch_write_a: assert property (
        (wr && hit_pchl && !cyc_end && !I_PCL_WR && !I_RETURN_OP) |=> s_q.pc == $past(s_q.pc))
        else $error("latch write moved the program counter");

    wake_pcl_a: assert property (
        (I_PCL_WR && s_q.st == ST_WAKE) |=> s_q.pc == {$past(s_q.pchl), $past(I_PCL_DATA)})
        else $error("PC low write lost after wake");

    reset_state_a: assert property (
        $rose(rst_n) |-> (s_q.st == ST_RUN && s_q.pc == RST_PC && s_q.peb == RST_PREG))
        else $error("state not cleared after reset");

    core_src_vec_a: assert property (
        (s_q.st == ST_RUN && cyc_end && s_q.ictl[B_GIE] && !I_RETURN_OP && !I_PCL_WR && !I_SLEEP_OP
         && ((s_q.ictl[B_TIE] && s_q.ictl[B_TIF]) || (s_q.ictl[B_PIE] && s_q.ictl[B_PIF])
             || (s_q.ictl[B_RBIE] && s_q.ictl[B_RBIF]))) |=> O_FLUSH)
        else $error("enabled core flag did not vector");

    periph_vec_a: assert property (
        (s_q.st == ST_RUN && cyc_end && s_q.ictl[B_GIE] && s_q.ictl[B_PERIPH_IRQ_ENABLE] && !I_RETURN_OP && !I_PCL_WR
         && !I_SLEEP_OP && ((|(s_q.pfa & s_q.pea)) || (|(s_q.pfb & s_q.peb)))) |=> O_FLUSH)
        else $error("enabled peripheral flag did not vector");

    wake_one_a: assert property (
        (s_q.st == ST_WAKE && cyc_end && !I_PCL_WR) |=> s_q.pc == 13'($past(s_q.pc) + 13'h1))
        else $error("instruction after sleep skipped");

    pchl_mirror_a: assert property (
        (rd_setup && idx[6:0] == IDX_PCHL[6:0]) |=> O_PRDATA[7:0] == {3'h0, $past(s_q.pchl)})
        else $error("mirrored latch read wrong");

    push_once_a: assert property (
        O_PUSH |=> !O_PUSH && !O_FLUSH)
        else $error("return address stacked twice");

endmodule // ivu_top
